/* core/sfp_cfg.svh */
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// Command framing
`define SFP_OPC_PARAM_READ 8'h5a
`define SFP_ADDR_BYTES 3'd3
`define SFP_DUMMY_BYTES 3'd1
`define SFP_BLANK_BYTE 8'hff

// Signature and header
`define SFP_SIG_WORD 32'h50444653
`define SFP_HDR_MINOR 8'h00
`define SFP_HDR_MAJOR 8'h01
`define SFP_NUM_HDRS 8'h01
`define SFP_TBL0_ID 8'h00
`define SFP_TBL_MINOR 8'h00
`define SFP_TBL_MAJOR 8'h01
`define SFP_TBL0_LEN 8'h09
`define SFP_TBL0_PTR 24'h000030
`define SFP_TBL1_LEN 8'h04
`define SFP_TBL1_PTR 24'h000060

// Standard flash table bytes
`define SFP_B30_ERASE_CAPS 8'he5
`define SFP_B31_ERASE4K_OPC 8'h20
`define SFP_B32_FREAD_CAPS 8'h81
`define SFP_DENSITY_WORD 32'h007fffff
`define SFP_B3C_DUAL_WAIT 8'h08
`define SFP_B3D_DUAL_OPC 8'h3b
`define SFP_NOSUP_WAIT 8'h00
`define SFP_B40_MULTI_CAPS 8'hee
`define SFP_SECT1_SIZE 8'h0c
`define SFP_SECT1_OPC 8'h20
`define SFP_SECT2_SIZE 8'h10
`define SFP_SECT2_OPC 8'hd8
`define SFP_SECT_ABSENT 8'h00

// Vendor table
`define SFP_VCC_MAX 16'h3600
`define SFP_VCC_MIN 16'h2700
`define SFP_FEAT_WORD 16'h4ff6
`define SFP_LOCK_WORD 16'hcffe

`endif

/* core/sfp_pkg.sv */
package sfp_pkg;
   typedef enum logic [4:0] {
      SFP_IDLE = 5'b00001,
      SFP_OPC = 5'b00010,
      SFP_ADDR = 5'b00100,
      SFP_DUMMY = 5'b01000,
      SFP_DATA = 5'b10000
   } sfp_state_t;
endpackage : sfp_pkg

/* core/sfp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Async in, synced out
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] rst_val_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         meta <= rst_val_i;
         sync_o <= rst_val_i;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule : sfp_sync
`default_nettype wire

/* core/sfp_rom.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfp_cfg.svh"
module sfp_rom
   import sfp_pkg::*;
#(
   parameter logic [7:0] VENDOR_ID = 8'h5c // Arbitrary value
) (
   // Lookup
   input wire logic [23:0] addr_i,
   output logic [7:0] data_o
);
   localparam logic [31:0] SIG = `SFP_SIG_WORD;
   localparam logic [31:0] DEN = `SFP_DENSITY_WORD;
   localparam logic [23:0] P0 = `SFP_TBL0_PTR;
   localparam logic [23:0] P1 = `SFP_TBL1_PTR;
   localparam logic [15:0] VMAX = `SFP_VCC_MAX;
   localparam logic [15:0] VMIN = `SFP_VCC_MIN;
   localparam logic [15:0] FEAT = `SFP_FEAT_WORD;
   localparam logic [15:0] LOCK = `SFP_LOCK_WORD;

   always_comb begin
      data_o = `SFP_BLANK_BYTE;
      if (addr_i[23:8] == 16'h0000) begin
         case (addr_i[7:0])
            8'h00: data_o = SIG[7:0];
            8'h01: data_o = SIG[15:8];
            8'h02: data_o = SIG[23:16];
            8'h03: data_o = SIG[31:24];
            8'h04: data_o = `SFP_HDR_MINOR;
            8'h05: data_o = `SFP_HDR_MAJOR;
            8'h06: data_o = `SFP_NUM_HDRS;
            8'h08: data_o = `SFP_TBL0_ID;
            8'h09: data_o = `SFP_TBL_MINOR;
            8'h0a: data_o = `SFP_TBL_MAJOR;
            8'h0b: data_o = `SFP_TBL0_LEN;
            8'h0c: data_o = P0[7:0];
            8'h0d: data_o = P0[15:8];
            8'h0e: data_o = P0[23:16];
            8'h10: data_o = VENDOR_ID;
            8'h11: data_o = `SFP_TBL_MINOR;
            8'h12: data_o = `SFP_TBL_MAJOR;
            8'h13: data_o = `SFP_TBL1_LEN;
            8'h14: data_o = P1[7:0];
            8'h15: data_o = P1[15:8];
            8'h16: data_o = P1[23:16];
            8'h30: data_o = `SFP_B30_ERASE_CAPS;
            8'h31: data_o = `SFP_B31_ERASE4K_OPC;
            8'h32: data_o = `SFP_B32_FREAD_CAPS;
            8'h34: data_o = DEN[7:0];
            8'h35: data_o = DEN[15:8];
            8'h36: data_o = DEN[23:16];
            8'h37: data_o = DEN[31:24];
            8'h38, 8'h3a, 8'h3e, 8'h46, 8'h4a: data_o = `SFP_NOSUP_WAIT;
            8'h3c: data_o = `SFP_B3C_DUAL_WAIT;
            8'h3d: data_o = `SFP_B3D_DUAL_OPC;
            8'h40: data_o = `SFP_B40_MULTI_CAPS;
            8'h4c: data_o = `SFP_SECT1_SIZE;
            8'h4d: data_o = `SFP_SECT1_OPC;
            8'h4e: data_o = `SFP_SECT2_SIZE;
            8'h4f: data_o = `SFP_SECT2_OPC;
            8'h50, 8'h52: data_o = `SFP_SECT_ABSENT;
            8'h60: data_o = VMAX[7:0];
            8'h61: data_o = VMAX[15:8];
            8'h62: data_o = VMIN[7:0];
            8'h63: data_o = VMIN[15:8];
            8'h64: data_o = FEAT[7:0];
            8'h65: data_o = FEAT[15:8];
            8'h68: data_o = LOCK[7:0];
            8'h69: data_o = LOCK[15:8];
            default: data_o = `SFP_BLANK_BYTE;
         endcase
      end
   end
endmodule : sfp_rom
`default_nettype wire

/* core/sfp_param_read.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfp_cfg.svh"
module sfp_param_read
   import sfp_pkg::*;
#(
   parameter logic [7:0] VENDOR_ID = 8'h5c // Arbitrary value
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Serial link pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   // Status
   output logic busy_o,
   output logic bad_opcode_o
);
   logic sclk_s;
   logic cs_n_s;
   logic si_s;
   logic sclk_d;
   logic rise;
   logic fall;
   sfp_state_t state;
   logic [2:0] bit_cnt;
   logic [1:0] byte_cnt;
   logic [7:0] shift_in;
   logic [7:0] next_byte;
   logic [23:0] addr;
   logic [7:0] rom_data;
   logic [7:0] shift_out;
   logic byte_done;

   // One decode for the sequencer and the s_opc_taken/s_opc_foreign checks
   function automatic logic is_discoverable_param_read(input logic [7:0] opc);
      return opc == `SFP_OPC_PARAM_READ;
   endfunction : is_discoverable_param_read

   sfp_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .async_i({sclk_i, cs_n_i, si_i}),
      .rst_val_i(3'b010),
      .sync_o({sclk_s, cs_n_s, si_s})
   );

   sfp_rom #(
      .VENDOR_ID(VENDOR_ID)
   ) u_rom (
      .addr_i(addr),
      .data_o(rom_data)
   );

   // Edge detect on the synchronised copy only
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   assign rise = sclk_s & ~sclk_d & ~cs_n_s;
   assign fall = ~sclk_s & sclk_d & ~cs_n_s;
   assign next_byte = {shift_in[6:0], si_s};
   assign byte_done = rise && (bit_cnt == 3'd7);

   // Input bit counter, sampled on rising edges
   always_ff @(posedge core_clk_i) begin
      if (srst_i || cs_n_s) begin
         bit_cnt <= 3'd0;
         shift_in <= 8'h00;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'd1;
         shift_in <= next_byte;
      end
   end

   // Command sequencing
   always_ff @(posedge core_clk_i) begin
      if (srst_i || cs_n_s) begin
         state <= SFP_OPC;
         byte_cnt <= 2'd0;
         bad_opcode_o <= srst_i ? 1'b0 : bad_opcode_o;
      end else begin
         case (state)
            SFP_IDLE: begin
               state <= SFP_IDLE;
            end
            SFP_OPC: begin
               if (byte_done) begin
                  if (is_discoverable_param_read(next_byte)) begin
                     state <= SFP_ADDR;
                     bad_opcode_o <= 1'b0;
                  end else begin
                     state <= SFP_IDLE;
                     bad_opcode_o <= 1'b1;
                  end
               end
            end
            SFP_ADDR: begin
               if (byte_done) begin
                  if (byte_cnt == 2'(`SFP_ADDR_BYTES - 3'd1)) begin
                     byte_cnt <= 2'd0;
                     state <= SFP_DUMMY;
                  end else begin
                     byte_cnt <= byte_cnt + 2'd1;
                  end
               end
            end
            SFP_DUMMY: begin
               if (byte_done) begin
                  if (byte_cnt == 2'(`SFP_DUMMY_BYTES - 3'd1)) begin
                     state <= SFP_DATA;
                  end else begin
                     byte_cnt <= byte_cnt + 2'd1;
                  end
               end
            end
            SFP_DATA: begin
               state <= SFP_DATA;
            end
            default: begin
               state <= SFP_IDLE;
            end
         endcase
      end
   end

   // Address capture and advance
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         addr <= 24'h000000;
      end else if (state == SFP_ADDR && byte_done) begin
         addr <= {addr[15:0], next_byte};
      end else if (state == SFP_DATA && byte_done) begin
         addr <= addr + 24'h000001;
      end
   end

   // Output shifter: first bit appears on the falling edge ending the dummy byte
   always_ff @(posedge core_clk_i) begin
      if (srst_i || cs_n_s) begin
         shift_out <= 8'hff;
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else if (fall && state == SFP_DATA) begin
         so_oe_o <= 1'b1;
         if (bit_cnt == 3'd0) begin
            so_o <= rom_data[7];
            shift_out <= {rom_data[6:0], 1'b1};
         end else begin
            so_o <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b1};
         end
      end
   end

   assign busy_o = ~cs_n_s && (state != SFP_IDLE) && (state != SFP_OPC || bit_cnt != 3'd0);

   // Checks
   sequence s_cmd_done;
      state == SFP_DUMMY && byte_done;
   endsequence

   a_data_after_dummy: assert property (@(posedge core_clk_i) disable iff (srst_i)
      so_oe_o |-> state == SFP_DATA)
      else $error("output driven before dummy byte finished");

   a_enter_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_cmd_done |=> state == SFP_DATA)
      else $error("data phase not entered after dummy byte");

   a_cs_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cs_n_s |=> !so_oe_o && state == SFP_OPC)
      else $error("output not released on deselect");

   a_opcode_match: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_OPC && byte_done && next_byte == `SFP_OPC_PARAM_READ && !cs_n_s |=> state == SFP_ADDR)
      else $error("read opcode not accepted");

   a_opcode_reject: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_OPC && byte_done && next_byte != `SFP_OPC_PARAM_READ && !cs_n_s |=> state == SFP_IDLE)
      else $error("foreign opcode accepted");

   a_addr_advance: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DATA && byte_done && !cs_n_s |=> addr == $past(addr) + 24'h000001)
      else $error("address did not advance");

   a_msb_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
      fall && state == SFP_DATA && bit_cnt == 3'd0 |=> so_o == $past(rom_data[7]))
      else $error("first bit is not msb");

   a_out_on_fall: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !fall && !cs_n_s |=> $stable(so_o))
      else $error("output changed away from falling edge");

   a_signature: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000000 |-> rom_data == 8'h53)
      else $error("signature byte wrong");

   a_blank_fill: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr[23:8] != 16'h0000 |-> rom_data == `SFP_BLANK_BYTE)
      else $error("undefined address not blank");

   // Frame steps, built into the checks below
   sequence s_opc_taken;
      state == SFP_OPC && byte_done && is_discoverable_param_read(next_byte);
   endsequence

   sequence s_opc_foreign;
      state == SFP_OPC && byte_done && !is_discoverable_param_read(next_byte);
   endsequence

   sequence s_last_addr;
      state == SFP_ADDR && byte_done && byte_cnt == 2'd2;
   endsequence

   sequence s_data_byte_end;
      state == SFP_DATA && byte_done;
   endsequence

   sequence s_later_bit_out;
      fall && state == SFP_DATA && bit_cnt != 3'd0;
   endsequence

   a_bad_opcode_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_opc_foreign |=> bad_opcode_o)
      else $error("foreign opcode not flagged");

   a_bad_opcode_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_opc_taken |=> !bad_opcode_o)
      else $error("flag not cleared by read opcode");

   a_refused_silent: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_IDLE |-> !so_oe_o)
      else $error("refused frame drives output");

   a_refused_stays: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_IDLE && !cs_n_s |=> state == SFP_IDLE)
      else $error("refused frame resumed");

   a_opc_wait: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_OPC && !byte_done && !cs_n_s |=> state == SFP_OPC)
      else $error("opcode phase left early");

   a_bit_count: assert property (@(posedge core_clk_i) disable iff (srst_i)
      rise |=> bit_cnt == $past(bit_cnt) + 3'd1)
      else $error("bit counter missed a rising edge");

   a_bit_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !rise && !cs_n_s |=> $stable(bit_cnt))
      else $error("bit counter moved without an edge");

   a_addr_wait: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_ADDR && !byte_done && !cs_n_s |=> state == SFP_ADDR)
      else $error("address phase left early");

   a_addr_byte_in: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_ADDR && byte_done |=> addr[7:0] == $past(next_byte))
      else $error("address byte not captured");

   a_addr_count_up: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_ADDR && byte_done && byte_cnt != 2'd2 |=> byte_cnt == $past(byte_cnt) + 2'd1)
      else $error("address byte count wrong");

   a_addr_to_dummy: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_last_addr |=> state == SFP_DUMMY && byte_cnt == 2'd0)
      else $error("dummy phase not entered");

   a_dummy_wait: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DUMMY && !byte_done && !cs_n_s |=> state == SFP_DUMMY)
      else $error("dummy phase cut short");

   a_addr_held: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DUMMY |=> $stable(addr))
      else $error("address moved in dummy phase");

   a_oe_no_early: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(so_oe_o) |-> $past(fall) && $past(state) == SFP_DATA)
      else $error("output enabled off a data falling edge");

   a_oe_holds: assert property (@(posedge core_clk_i) disable iff (srst_i)
      so_oe_o && !cs_n_s |=> so_oe_o)
      else $error("output dropped while selected");

   a_busy_in_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DATA && !cs_n_s |-> busy_o)
      else $error("busy low in data phase");

   // A cut frame must leave no count behind for the next one
   a_deselect_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cs_n_s |=> bit_cnt == 3'd0 && byte_cnt == 2'd0 && so_o == 1'b0)
      else $error("frame state kept over deselect");

   a_shift_bits: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_later_bit_out |=> so_o == $past(shift_out[7]))
      else $error("bit order broken");

   a_data_stays: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DATA && !cs_n_s |=> state == SFP_DATA)
      else $error("data phase left while selected");

   a_addr_frozen_out: assert property (@(posedge core_clk_i) disable iff (srst_i)
      state == SFP_DATA && !byte_done |=> $stable(addr))
      else $error("address moved inside a byte");

   a_next_byte_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_data_byte_end |=> bit_cnt == 3'd0 && state == SFP_DATA)
      else $error("next byte not started");

   // Image spot checks at fixed offsets
   a_hdr_count: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000006 |-> rom_data == 8'h01)
      else $error("header count wrong");

   a_hdr_unused: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000007 |-> rom_data == 8'hff)
      else $error("unused header byte not blank");

   a_tbl_pointer: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h00000c |-> rom_data == 8'h30)
      else $error("first table pointer wrong");

   a_erase_caps: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000030 |-> rom_data == 8'he5)
      else $error("erase capability byte wrong");

   a_fread_caps: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000032 |-> rom_data == 8'h81)
      else $error("fast read capability byte wrong");

   a_lock_word: assert property (@(posedge core_clk_i) disable iff (srst_i)
      addr == 24'h000069 |-> rom_data == 8'hcf)
      else $error("lock word high byte wrong");
endmodule : sfp_param_read
`default_nettype wire

/* test/sfp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
   // Core clock paces the link
   input wire logic core_clk_i,
   // Device side
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b1;
   end
   // Read late in the high phase, safely past the sync delay
   task automatic bit_xfer(input logic din, output logic dout, output logic oe);
      sclk_o = 1'b0;
      si_o = din;
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      // Released line shows the inverse, so a missing enable cannot pass
      dout = so_oe_i ? so_i : ~so_i;
      oe = so_oe_i;
   endtask : bit_xfer
   task automatic put_byte(input logic [7:0] b, output logic oe_any);
      logic d;
      logic o;
      oe_any = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(b[i], d, o);
         oe_any = oe_any | o;
      end
   endtask : put_byte
   // Data in is not ours to hold here, so it toggles
   task automatic get_bits(input int n, output logic [7:0] b, output logic oe_all);
      logic d;
      logic o;
      b = 8'h00;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++) begin
         bit_xfer(~si_o, d, o);
         b = {b[6:0], d};
         oe_all = oe_all & o;
      end
   endtask : get_bits
   task automatic open_frame(input logic [7:0] opc, input logic [23:0] a, output logic oe_any);
      logic o;
      cs_n_o = 1'b0;
      repeat (4) @(negedge core_clk_i);
      put_byte(opc, oe_any);
      for (int i = 2; i >= 0; i--) begin
         put_byte(a[8*i +: 8], o);
         oe_any = oe_any | o;
      end
      put_byte(8'ha5, o);
      oe_any = oe_any | o;
   endtask : open_frame
   task automatic close_frame();
      sclk_o = 1'b0;
      repeat (4) @(negedge core_clk_i);
      cs_n_o = 1'b1;
      si_o = ~si_o;
      repeat (4) @(negedge core_clk_i);
   endtask : close_frame
endmodule : sfp_host_model
`default_nettype wire

/* test/sfp_param_read_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_param_read_tb;
   localparam logic [7:0] VEND = 8'h3e; // Arbitrary value
   logic core_clk;
   logic srst;
   logic sclk;
   logic cs_n;
   logic si;
   logic so;
   logic so_oe;
   logic busy;
   logic bad_opcode;
   logic oe;
   logic [7:0] d;
   int miscompares = 0;
   int total_checks = 0;
   sfp_param_read #(.VENDOR_ID(VEND)) dut_u (.core_clk_i(core_clk), .srst_i(srst), .sclk_i(sclk),
      .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .busy_o(busy), .bad_opcode_o(bad_opcode));
   sfp_host_model host_u (.core_clk_i(core_clk), .so_i(so), .so_oe_i(so_oe), .sclk_o(sclk),
      .cs_n_o(cs_n), .si_o(si));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte
   task automatic check_flag(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag
   // Byte 10h holds the vendor code, so the header image leaves it zero
   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      logic [191:0] hdr = 192'h53464450_000101ff_00000109_300000ff_00000104_600000ff;
      logic [287:0] tbl = 288'he52081ff_ffff7f00_00ff00ff_083b00ff_eeffffff_ffff00ff_ffff00ff_0c2010d8_00ff00ff;
      logic [127:0] ven = 128'h00360027_f64fffff_fecfffff_ffffffff;
      int k = int'(a[7:0]);
      if (a[23:8] != 16'h0000) return 8'hff;
      if (k == 16) return VEND;
      if (k < 24) return hdr[8*(23-k) +: 8];
      if (k >= 48 && k < 84) return tbl[8*(83-k) +: 8];
      if (k >= 96 && k < 112) return ven[8*(111-k) +: 8];
      return 8'hff;
   endfunction : exp_byte
   task automatic rd(input logic [7:0] opc, input logic [23:0] a, input int n);
      host_u.open_frame(opc, a, oe);
      check_flag("oe during command", 1'b0, oe);
      if (opc == 8'h5a) begin
         check_flag("busy", 1'b1, busy);
      end else begin
         check_flag("busy refused", 1'b0, busy);
      end
      for (int i = 0; i < n; i++) begin
         host_u.get_bits(8, d, oe);
         if (opc == 8'h5a) begin
            check_byte("data", exp_byte(a + 24'(i)), d);
            check_flag("oe in data", 1'b1, oe);
         end else begin
            check_flag("oe refused", 1'b0, oe);
         end
      end
   endtask : rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // Whole run is about 10.4k cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      miscompares++;
      $display("watchdog expired");
      stop_test();
   end
   initial begin
      srst = 1'b1;
      repeat (12) @(negedge core_clk);
      check_flag("oe in reset", 1'b0, so_oe);
      check_flag("so in reset", 1'b0, so);
      check_flag("busy in reset", 1'b0, busy);
      check_flag("bad opcode in reset", 1'b0, bad_opcode);
      srst = 1'b0;
      repeat (6) @(negedge core_clk);
      $display("test reset done");
      rd(8'h5a, 24'h000000, 112);
      host_u.close_frame();
      check_flag("oe after frame", 1'b0, so_oe);
      $display("test full image done");
      rd(8'h5a, 24'h010030, 2);
      host_u.close_frame();
      rd(8'h5a, 24'h00005e, 3);
      host_u.close_frame();
      $display("test address decode done");
      rd(8'h5a, 24'h000000, 1);
      host_u.get_bits(3, d, oe);
      check_byte("partial byte", 8'h02, d);
      check_flag("oe partial", 1'b1, oe);
      host_u.close_frame();
      check_flag("oe after abort", 1'b0, so_oe);
      check_flag("busy after abort", 1'b0, busy);
      rd(8'h5a, 24'h00004c, 4);
      host_u.close_frame();
      $display("test abort done");
      rd(8'h03, 24'h000000, 2);
      check_flag("bad opcode", 1'b1, bad_opcode);
      host_u.close_frame();
      rd(8'h5a, 24'h000004, 1);
      host_u.close_frame();
      check_flag("bad opcode cleared", 1'b0, bad_opcode);
      $display("test refused opcode done");
      stop_test();
   end
endmodule : sfp_param_read_tb
`default_nettype wire
